//--- pcg_host_decode.sv
// host bus glue and window decode of the lcd controller, with apb status
//
// Implementation choices: the APB slave port and the register offsets.
module pcg_host_decode
  import pcg_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  // host card bus pins
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_low_byte_write_strobe_n,
  input wire logic i_high_byte_enable_n,
  input wire logic i_rd_wr_n,
  input wire logic i_bus_clock,
  input wire logic [16:0] i_addr,
  input wire logic [15:0] i_data,
  output logic [15:0] o_data,
  output logic o_data_oe,
  output logic o_wait_n,
  input wire logic [3:0] i_config_straps,
  input wire logic i_interface_mode_strap,
  // display memory arbiter port
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [1:0] o_mem_be,
  output logic [16:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  pcg_sync_if sync ();

  pcg_sync u_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_cs_n(i_cs_n),
    .i_rd_n(i_rd_n),
    .i_low_byte_write_strobe_n(i_low_byte_write_strobe_n),
    .i_high_byte_enable_n(i_high_byte_enable_n),
    .i_rd_wr_n(i_rd_wr_n),
    .i_bus_clock(i_bus_clock),
    .i_addr(i_addr),
    .i_data(i_data),
    .i_config_straps(i_config_straps),
    .i_interface_mode_strap(i_interface_mode_strap),
    .o_sync(sync)
  );

  typedef struct packed {
    pcg_state_t st;
    logic [1:0] capt_cnt;
    logic captured;
    logic mode2;
    logic big;
    logic type_ok;
    logic hold;
    logic is_rd;
    logic [16:0] ofs;
    logic [15:0] rdata;
    logic wait_n;
    logic data_oe;
    logic mem_req;
    logic mem_we;
    logic [1:0] be;
    logic [15:0] wdata;
    logic [15:0] count;
    logic [15:0] edges;
    logic bclk_prev;
    logic [PCG_REG_WORDS-1:0][15:0] regs;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pcg_main_state_t;

  pcg_main_state_t s_q;
  pcg_main_state_t s_d;

  logic rd_act;
  logic wr_act;
  logic lo_en;
  logic hi_en;
  logic go;
  logic [3:0] ridx;
  logic [31:0] apb_rd;
  logic [15:0] wr_ord;

  //--------------------------------------------------------------------
  // strobe decode per host mode
  //--------------------------------------------------------------------
  always_comb begin
    if (s_q.mode2) begin
      rd_act = ~sync.rd_n;
      wr_act = ~sync.we0_n;
      lo_en = 1'b1;
      hi_en = ~sync.we1_n;
    end else begin
      rd_act = ~sync.rd_n | ~sync.rd_wr_n;
      wr_act = ~sync.we0_n | ~sync.we1_n;
      lo_en = ~sync.we0_n | ~sync.rd_n;
      hi_en = ~sync.we1_n | ~sync.rd_wr_n;
    end
    // strobes arrive through the synchroniser, free of the bus clock
    go = s_q.captured & s_q.type_ok & ~sync.cs_n & (rd_act | wr_act);
    ridx = sync.addr[4:1];
    // host write data in core byte order
    wr_ord = pcg_order(sync.data, s_q.big);
  end

  //--------------------------------------------------------------------
  // apb read mux
  //--------------------------------------------------------------------
  always_comb begin
    apb_rd = 32'h0000_0000;
    if (paddr == PCG_STATUS_OFS) begin
      apb_rd[PCG_ST_MODE2_BIT] = s_q.mode2;
      apb_rd[PCG_ST_BIG_BIT] = s_q.big;
      apb_rd[PCG_ST_TYPE_OK_BIT] = s_q.type_ok;
      apb_rd[PCG_ST_CAPT_BIT] = s_q.captured;
      apb_rd[PCG_ST_BUSY_BIT] = s_q.st != PCG_IDLE;
      apb_rd[PCG_ST_EDGES_LSB +: 16] = s_q.edges;
    end else if (paddr == PCG_CTRL_OFS) begin
      apb_rd[PCG_CTRL_HOLD_BIT] = s_q.hold;
    end else if (paddr == PCG_COUNT_OFS) begin
      apb_rd[15:0] = s_q.count;
    end
  end

  //--------------------------------------------------------------------
  // next state
  //--------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // strap capture once the synchroniser has filled after reset
    if (!s_q.captured) begin
      if (s_q.capt_cnt == PCG_CAPT_DELAY) begin
        s_d.captured = 1'b1;
        s_d.mode2 = sync.interface_mode_strap;
        s_d.big = sync.config_straps[3];
        s_d.type_ok = sync.config_straps[2:0] == PCG_HOST_TYPE_GENERIC;
      end else begin
        s_d.capt_cnt = s_q.capt_cnt + 2'h1;
      end
    end
    // bus clock edges seen by the core clock
    s_d.bclk_prev = sync.bclk;
    if (sync.bclk && !s_q.bclk_prev) begin
      s_d.edges = s_q.edges + 16'h0001;
    end
    // host access sequencer
    case (s_q.st)
      PCG_IDLE: begin
        if (go) begin
          s_d.ofs = sync.addr;
          s_d.is_rd = rd_act;
          s_d.be = {hi_en, lo_en};
          s_d.wdata = pcg_order(sync.data, s_q.big);
          s_d.count = s_q.count + 16'h0001;
          if (pcg_is_mem(sync.addr)) begin
            s_d.st = PCG_ARB;
            s_d.wait_n = 1'b0;
            s_d.mem_req = ~s_q.hold;
            s_d.mem_we = ~rd_act;
          end else if (pcg_is_reg(sync.addr)) begin
            s_d.st = PCG_DONE;
            s_d.data_oe = rd_act;
            s_d.rdata = s_q.regs[ridx];
            if (!rd_act && lo_en) begin
              s_d.regs[ridx][7:0] = wr_ord[7:0];
            end
            if (!rd_act && hi_en) begin
              s_d.regs[ridx][15:8] = wr_ord[15:8];
            end
          end else begin
            s_d.st = PCG_DONE;
            s_d.data_oe = rd_act;
            s_d.rdata = 16'h0000;
          end
        end
      end
      PCG_ARB: begin
        s_d.mem_req = ~s_q.hold;
        if (s_q.mem_req && i_mem_ack) begin
          s_d.mem_req = 1'b0;
          s_d.wait_n = 1'b1;
          s_d.rdata = i_mem_rdata;
          s_d.data_oe = s_q.is_rd;
          s_d.st = PCG_DONE;
        end
      end
      PCG_DONE: begin
        if (sync.cs_n || !(rd_act || wr_act)) begin
          s_d.data_oe = 1'b0;
          s_d.st = PCG_IDLE;
        end
      end
      default: begin
        s_d.st = PCG_IDLE;
      end
    endcase
    // apb slave answers one cycle into the access phase
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = pwrite ? 32'h0000_0000 : apb_rd;
      if (paddr != PCG_STATUS_OFS && paddr != PCG_CTRL_OFS && paddr != PCG_COUNT_OFS) begin
        s_d.pslverr = 1'b1;
      end else if (pwrite && paddr == PCG_CTRL_OFS) begin
        s_d.hold = pwdata[PCG_CTRL_HOLD_BIT];
      end
    end
  end

  // state register
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.st <= PCG_IDLE;
      s_q.wait_n <= 1'b1;
      s_q.hold <= PCG_CTRL_HOLD_RST;
    end else begin
      s_q <= s_d;
    end
  end

  //--------------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------------
  assign o_data = pcg_order(s_q.rdata, s_q.big);
  assign o_data_oe = s_q.data_oe;
  assign o_wait_n = s_q.wait_n;
  assign o_mem_req = s_q.mem_req;
  assign o_mem_we = s_q.mem_we;
  assign o_mem_be = s_q.be;
  assign o_mem_addr = s_q.ofs;
  assign o_mem_wdata = s_q.wdata;
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  mem_select_a: assert property (s_q.st == PCG_IDLE && go && sync.addr <= PCG_MEM_LAST
    |=> s_q.st == PCG_ARB && !s_q.wait_n) else $error("memory offset not sent to arbiter");
  reg_select_a: assert property (s_q.st == PCG_IDLE && go && sync.addr >= PCG_REG_FIRST
    |=> s_q.st == PCG_DONE && !s_q.mem_req) else $error("register offset misrouted");
  unused_quiet_a: assert property (s_q.st == PCG_IDLE && go && !pcg_is_mem(sync.addr)
    && !pcg_is_reg(sync.addr) |=> $stable(s_q.regs) && !s_q.mem_req && s_q.rdata == 16'h0000)
    else $error("unused offset had a side effect");
  window_bound_a: assert property (s_q.mem_req |-> s_q.ofs <= PCG_MEM_LAST)
    else $error("memory request outside window");
  wait_hold_a: assert property (s_q.st == PCG_ARB && !(s_q.mem_req && i_mem_ack)
    |=> !s_q.wait_n) else $error("wait released before arbitration");
  wait_release_a: assert property (s_q.st == PCG_ARB && s_q.mem_req && i_mem_ack
    |=> s_q.wait_n && s_q.st == PCG_DONE && s_q.rdata == $past(i_mem_rdata))
    else $error("wait not released on grant");
  strap_gate_a: assert property (s_q.st == PCG_IDLE && s_q.captured && !s_q.type_ok
    |=> s_q.st == PCG_IDLE [*2]) else $error("access taken without valid straps");
  mode_fixed_a: assert property (s_q.captured |=> $stable(s_q.mode2) && $stable(s_q.big))
    else $error("strap choice changed after capture");
  shared_strobe_a: assert property (s_q.st == PCG_IDLE && go && s_q.mode2
    |=> s_q.be[0] && s_q.is_rd == $past(~sync.rd_n)) else $error("mode two strobes misread");

endmodule

//--- pcg_pkg.sv
// constants, types and helpers of the pc card host glue decode block
//----------------------------------------------------------------------
// How it works
//----------------------------------------------------------------------
package pcg_pkg;

  //--------------------------------------------------------------------
  // host window decode
  //--------------------------------------------------------------------
  localparam int PCG_ADDR_W = 17;
  localparam logic [16:0] PCG_MEM_LAST = 17'h1_3FFF;
  localparam logic [16:0] PCG_REG_FIRST = 17'h1_FFE0;
  localparam logic [2:0] PCG_HOST_TYPE_GENERIC = 3'h7;
  localparam int PCG_REG_WORDS = 16;
  localparam int PCG_SYNC_W = 44;
  localparam logic [1:0] PCG_CAPT_DELAY = 2'h3;

  //--------------------------------------------------------------------
  // apb register map and fields
  //--------------------------------------------------------------------
  localparam logic [11:0] PCG_STATUS_OFS = 12'h000;
  localparam logic [11:0] PCG_CTRL_OFS = 12'h004;
  localparam logic [11:0] PCG_COUNT_OFS = 12'h008;
  localparam int PCG_ST_MODE2_BIT = 0;
  localparam int PCG_ST_BIG_BIT = 1;
  localparam int PCG_ST_TYPE_OK_BIT = 2;
  localparam int PCG_ST_CAPT_BIT = 3;
  localparam int PCG_ST_BUSY_BIT = 4;
  localparam int PCG_ST_EDGES_LSB = 16;
  localparam int PCG_CTRL_HOLD_BIT = 0;
  localparam logic PCG_CTRL_HOLD_RST = 1'b0;

  typedef enum logic [1:0] {
    PCG_IDLE = 2'b00,
    PCG_ARB = 2'b01,
    PCG_DONE = 2'b10
  } pcg_state_t;

  // offset lies in display memory
  function automatic logic pcg_is_mem(input logic [16:0] ofs);
    return ofs <= PCG_MEM_LAST;
  endfunction

  // offset lies in the register range
  function automatic logic pcg_is_reg(input logic [16:0] ofs);
    return ofs >= PCG_REG_FIRST;
  endfunction

  // byte swap for big endian hosts
  function automatic logic [15:0] pcg_order(input logic [15:0] d, input logic big);
    return big ? {d[7:0], d[15:8]} : d;
  endfunction

endpackage

//--- pcg_sync_if.sv
// interface carrying synchronised host pins to the decode logic
interface pcg_sync_if;
  logic cs_n;
  logic rd_n;
  logic we0_n;
  logic we1_n;
  logic rd_wr_n;
  logic bclk;
  logic [16:0] addr;
  logic [15:0] data;
  logic [3:0] config_straps;
  logic interface_mode_strap;
  modport src (output cs_n, rd_n, we0_n, we1_n, rd_wr_n, bclk, addr, data, config_straps,
    interface_mode_strap);
  modport dst (input cs_n, rd_n, we0_n, we1_n, rd_wr_n, bclk, addr, data, config_straps,
    interface_mode_strap);
endinterface

//--- pcg_sync.sv
// two flip-flop synchroniser for every host pin
module pcg_sync
  import pcg_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_low_byte_write_strobe_n,
  input wire logic i_high_byte_enable_n,
  input wire logic i_rd_wr_n,
  input wire logic i_bus_clock,
  input wire logic [16:0] i_addr,
  input wire logic [15:0] i_data,
  input wire logic [3:0] i_config_straps,
  input wire logic i_interface_mode_strap,
  pcg_sync_if.src o_sync
);

  typedef struct packed {
    logic [PCG_SYNC_W-1:0] s1;
    logic [PCG_SYNC_W-1:0] s2;
  } pcg_sync_state_t;

  pcg_sync_state_t s_q;
  pcg_sync_state_t s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d = s_q;
    s_d.s1 = {i_cs_n, i_rd_n, i_low_byte_write_strobe_n, i_high_byte_enable_n, i_rd_wr_n,
      i_bus_clock, i_addr, i_data, i_config_straps, i_interface_mode_strap};
    s_d.s2 = s_q.s1;
  end

  // strobes idle high after reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s_q <= '{s1: {5'h1F, 39'h00_0000_0000}, s2: {5'h1F, 39'h00_0000_0000}};
    end else begin
      s_q <= s_d;
    end
  end

  assign {o_sync.cs_n, o_sync.rd_n, o_sync.we0_n, o_sync.we1_n, o_sync.rd_wr_n, o_sync.bclk,
    o_sync.addr, o_sync.data, o_sync.config_straps, o_sync.interface_mode_strap} = s_q.s2;

endmodule

//--- pcg_host_model.sv
// host card bus model that drives the glue decode pins
module pcg_host_model (
  input wire logic i_mode2,
  input wire logic i_wait_n,
  input wire logic [15:0] i_data,
  output logic o_bus_clock,
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_low_byte_write_strobe_n,
  output logic o_high_byte_enable_n,
  output logic o_rd_wr_n,
  output logic [16:0] o_addr,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wait_q;

  // free running host bus clock, strobes idle high
  initial begin
    {o_cs_n, o_rd_n, o_low_byte_write_strobe_n, o_high_byte_enable_n, o_rd_wr_n} = 5'h1f;
    o_addr = 17'h0_0000;
    o_data = 16'h0000;
    o_bus_clock = 1'b0;
    forever #62.5 o_bus_clock = ~o_bus_clock;
  end

  // wait is brought into the host clock domain before use
  always @(posedge o_bus_clock) wait_q <= {wait_q[0], i_wait_n};

  // one word access; the cycle is stretched while wait is low
  task automatic access(input logic wr, input logic [16:0] a, input logic [15:0] wd,
    input logic [1:0] be, output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge o_bus_clock);
    o_addr <= a; // only the latched offset lines reach the block
    o_data <= wd;
    o_cs_n <= 1'b0;
    if (i_mode2) begin
      o_rd_n <= wr;
      o_low_byte_write_strobe_n <= !wr;
      o_high_byte_enable_n <= !be[1];
    end else begin
      o_rd_n <= !(!wr && be[0]);
      o_rd_wr_n <= !(!wr && be[1]);
      o_low_byte_write_strobe_n <= !(wr && be[0]);
      o_high_byte_enable_n <= !(wr && be[1]);
    end
    repeat (3) @(posedge o_bus_clock);
    while (wait_q[1] !== 1'b1 && n < 400) begin
      n++;
      @(posedge o_bus_clock);
    end
    rd = i_data;
    {o_cs_n, o_rd_n, o_low_byte_write_strobe_n, o_high_byte_enable_n, o_rd_wr_n} <= 5'h1f;
    o_addr <= ~a; // released lines do not keep the old value
    o_data <= ~wd;
    @(posedge o_bus_clock);
  endtask
endmodule

//--- testbench.sv
// self-checking bench of the host glue decode block
module testbench;
  import pcg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clock, i_rst_n, cs_n, rd_n, lo_n, hi_n, rw_n, bclk, oe, wt_n, req, we, ack;
  logic psel, penable, pwrite, pready, pslverr, mode, big, ok, err, s_we;
  logic [1:0] mbe, be, s_be;
  logic [3:0] straps;
  logic [16:0] ha, maddr, a, s_addr;
  logic [15:0] hwd, hrd, mwd, mrd, wd, hd, s_wd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st;
  logic [4:0] cfg [4] = '{5'h17, 5'h07, 5'h1f, 5'h15};
  logic [15:0] mem_q [0:131071] = '{default: 16'h0000};
  int mismatches = 0, total_checks = 0, acks = 0, acks0, cycles = 0, dly = 0;

  pcg_host_decode dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_low_byte_write_strobe_n(lo_n), .i_high_byte_enable_n(hi_n), .i_rd_wr_n(rw_n),
    .i_bus_clock(bclk), .i_addr(ha), .i_data(hwd), .o_data(hrd), .o_data_oe(oe),
    .o_wait_n(wt_n), .i_config_straps(straps), .i_interface_mode_strap(mode),
    .o_mem_req(req), .o_mem_we(we), .o_mem_be(mbe), .o_mem_addr(maddr), .o_mem_wdata(mwd),
    .i_mem_ack(ack), .i_mem_rdata(mrd), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pcg_host_model host_u (.i_mode2(mode), .i_wait_n(wt_n), .i_data(hrd), .o_bus_clock(bclk),
    .o_cs_n(cs_n), .o_rd_n(rd_n), .o_low_byte_write_strobe_n(lo_n),
    .o_high_byte_enable_n(hi_n), .o_rd_wr_n(rw_n), .o_addr(ha), .o_data(hwd));

  // core clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // display memory arbiter with random grant delay
  always @(posedge i_clock) begin
    ack <= 1'b0;
    mrd <= ~mrd;
    if (!req) dly <= $urandom % 5;
    else if (!ack && dly != 0) dly <= dly - 1;
    else if (!ack) begin
      ack <= 1'b1;
      acks <= acks + 1;
      {s_we, s_be, s_addr, s_wd} <= {we, mbe, maddr, mwd};
      mrd <= mem_q[maddr];
      if (we) mem_q[maddr] <= {mbe[1] ? mwd[15:8] : mem_q[maddr][15:8],
        mbe[0] ? mwd[7:0] : mem_q[maddr][7:0]};
    end
  end

  // hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end

  //--------------------------------------------------------------------
  // tasks
  //--------------------------------------------------------------------
  function automatic logic [15:0] swap(input logic [15:0] d, input logic b);
    return b ? {d[7:0], d[15:8]} : d;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata, penable} <= {1'b1, wr, ad, d, 1'b0};
    @(posedge i_clock);
    penable <= 1'b1;
    do @(posedge i_clock); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) mismatches++;
    st = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge i_clock);
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // strap settings, then memory, unused, register and hold traffic
  initial begin
    {psel, penable, pwrite, paddr, pwdata, i_rst_n, mode, straps} = '0;
    void'($urandom(32'h39fc));
    for (int c = 0; c < 4; c++) begin
      {mode, straps} <= cfg[c];
      i_rst_n <= 1'b0;
      repeat (5) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (10) @(posedge i_clock);
      big = cfg[c][3];
      ok = cfg[c][2:0] == 3'h7;
      chk(32'({wt_n, oe, req, pready}), 32'h8);
      apb(1'b0, PCG_STATUS_OFS, 32'h0);
      chk(32'(st[4:0]), 32'({2'b01, ok, big, cfg[c][4]}));
      for (int i = 0; i < 6; i++) begin
        a = (i == 0) ? 17'h1_3FFF : 17'($urandom % 32'h1_4000);
        wd = 16'($urandom);
        be = big ? 2'b11 : 2'($urandom % 3 + 1);
        if (mode) be[0] = 1'b1;
        acks0 = acks;
        host_u.access(1'b1, a, wd, be, hd);
        chk(32'(acks - acks0), 32'(ok));
        if (ok) chk(32'({s_we, s_be, s_addr}), 32'({1'b1, be, a}));
        if (ok) chk(32'(s_wd), 32'(swap(wd, big)));
        host_u.access(1'b0, a, 16'h0000, 2'b11, hd);
        if (ok) chk(32'(hd), 32'(swap(mem_q[a], big)));
        chk(32'(oe), 32'h0);
      end
      if (ok) begin
        acks0 = acks;
        host_u.access(1'b1, 17'h1_FFDE, wd, 2'b11, hd);
        host_u.access(1'b0, 17'h1_FFDE, 16'h0000, 2'b11, hd);
        chk(32'(hd), 32'h0);
        a = 17'h1_FFE0 + 17'(2 * ($urandom % 16));
        host_u.access(1'b1, a, wd, 2'b11, hd);
        host_u.access(1'b0, a, 16'h0000, 2'b11, hd);
        chk(32'(hd), 32'(wd));
        chk(32'(acks - acks0), 32'h0);
      end
      if (c == 0) begin
        apb(1'b0, PCG_CTRL_OFS, 32'h0);
        chk(st, 32'h0);
        apb(1'b1, PCG_CTRL_OFS, 32'h1);
        fork
          host_u.access(1'b1, 17'h0_0100, 16'h1234, 2'b11, hd);
          begin
            repeat (100) @(posedge i_clock);
            chk(32'({req, wt_n}), 32'h0);
            apb(1'b1, PCG_CTRL_OFS, 32'h0);
          end
        join
        chk(32'(mem_q[17'h0_0100]), 32'h1234);
        apb(1'b0, PCG_COUNT_OFS, 32'h0);
        chk(st, 32'd17);
        apb(1'b0, 12'h00C, 32'h0);
        chk(32'(err), 32'h1);
        chk(st, 32'h0);
      end
    end
    report_and_stop();
  end
endmodule
